// file: esc_loader.sv
// Purpose: Loads the switch configuration image from EEPROM after reset and holds it.
// Assumes: Straps are stable during reset; the register port follows a one-cycle strobe master.
// Notes: Software writes are taken only after loading ends.
// Notes on behaviour
// - After reset compare bytes zero and one with the signature; load only on match.
// - Byte two bits one to zero select LED mode; reset value three.
// - Byte four bit seven enables pause flow control; resets to one.
// - Byte four bit four enables half-duplex backpressure; resets to one.
// - Byte four bit three enables external MAC port flow control; resets to one.
// - Byte four bit two enables broadcast storm dropping; resets to zero.
// - Byte five bits four to three choose backpressure type; resets to zero.
// - Byte six bit seven keeps frames after sixteen collisions; resets to one.
// - Byte six bit four enables address aging; resets to one.
// - Byte six bit two checks carrier idle over 64 bits; resets to one.
// - Byte six bit one caps backoff at sixteen slots; resets to one.
//
// Design decision made here: the strobed register port.
`timescale 1ns/10ps
`include "esc_params.svh"
module esc_loader (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic [1:0] strap_led_mode,
    input  wire logic       strap_pause_enable,
    input  wire logic       strap_backpressure_enable,
    input  wire logic       strap_mac_flow_enable,
    input  wire logic       strap_bcast_storm_drop_enable,
    input  wire logic       strap_aging_enable,
    output logic            rom_req,
    output logic [7:0]      rom_addr,
    input  wire logic [7:0] rom_data,
    input  wire logic       rom_valid,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata,
    output logic [1:0]      led_mode,
    output logic            pause_enable,
    output logic            backpressure_enable,
    output logic            mac_flow_enable,
    output logic            bcast_storm_drop_enable,
    output logic [1:0]      backpressure_type,
    output logic            keep_after_max_collisions,
    output logic            aging_enable,
    output logic            carrier_idle_64,
    output logic            capped_backoff,
    output logic            cfg_ready,
    output logic            sig_valid
);
    esc_rom_if rd ();

    esc_pkg::esc_load_state_t st_q;
    logic [7:0] img_q [0:6];
    logic       start_q;
    logic [1:0] led_q;
    logic       pause_q;
    logic       bkp_q;
    logic       macfc_q;
    logic       storm_q;
    logic [1:0] bpt_q;
    logic       keep_q;
    logic       aging_q;
    logic       idle64_q;
    logic       capbo_q;
    logic       ready_q;
    logic       sigok_q;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic       sig_match;
    logic       apply_ok;
    logic       sw_wr;

    esc_rom_reader u_reader (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .rd        (rd.reader),
        .rom_req   (rom_req),
        .rom_addr  (rom_addr),
        .rom_data  (rom_data),
        .rom_valid (rom_valid)
    );

    assign rd.start  = start_q;
    assign sig_match = (img_q[0] == `ESC_SIG_BYTE0) && (img_q[1] == `ESC_SIG_BYTE1);
    assign apply_ok  = (st_q == esc_pkg::ESC_ST_APPLY) && sig_match && !rd.timed_out;
    assign sw_wr     = reg_wr && (st_q == esc_pkg::ESC_ST_RUN);

    // Sequences strap capture, image fetch and the signature decision.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_q    <= esc_pkg::ESC_ST_STRAP;
            start_q <= 1'b0;
            ready_q <= 1'b0;
            sigok_q <= 1'b0;
        end else begin
            start_q <= 1'b0;
            case (st_q)
                esc_pkg::ESC_ST_STRAP: begin
                    start_q <= 1'b1;
                    st_q    <= esc_pkg::ESC_ST_FETCH;
                end
                esc_pkg::ESC_ST_FETCH: begin
                    if (rd.done) begin
                        st_q <= esc_pkg::ESC_ST_APPLY;
                    end
                end
                esc_pkg::ESC_ST_APPLY: begin
                    sigok_q <= apply_ok;
                    ready_q <= 1'b1;
                    st_q    <= esc_pkg::ESC_ST_RUN;
                end
                esc_pkg::ESC_ST_RUN: begin
                    st_q <= esc_pkg::ESC_ST_RUN;
                end
                default: begin
                    st_q <= esc_pkg::ESC_ST_STRAP;
                end
            endcase
        end
    end

    // Holds the fetched image; the signature bytes stay writable afterwards.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i <= 6; i++) begin
                img_q[i] <= 8'h00;
            end
        end else if (rd.byte_valid && (st_q == esc_pkg::ESC_ST_FETCH)) begin
            img_q[rd.byte_idx] <= rd.byte_data;
        end else if (sw_wr && (reg_addr == `ESC_OFS_SIG0)) begin
            img_q[0] <= reg_wdata;
        end else if (sw_wr && (reg_addr == `ESC_OFS_SIG1)) begin
            img_q[1] <= reg_wdata;
        end
    end

    // Configuration fields: defaults, then straps for six of the ten fields, then EEPROM on a valid signature when the read did not time out.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            led_q    <= `ESC_RST_LED;
            pause_q  <= `ESC_RST_PAUSE;
            bkp_q    <= `ESC_RST_BKP;
            macfc_q  <= `ESC_RST_MACFC;
            storm_q  <= `ESC_RST_STORM;
            bpt_q    <= `ESC_RST_BPT;
            keep_q   <= `ESC_RST_KEEP;
            aging_q  <= `ESC_RST_AGING;
            idle64_q <= `ESC_RST_IDLE64;
            capbo_q  <= `ESC_RST_CAPBO;
        end else if (st_q == esc_pkg::ESC_ST_STRAP) begin
            led_q   <= strap_led_mode;
            pause_q <= strap_pause_enable;
            bkp_q   <= strap_backpressure_enable;
            macfc_q <= strap_mac_flow_enable;
            storm_q <= strap_bcast_storm_drop_enable;
            aging_q <= strap_aging_enable;
        end else if (apply_ok) begin
            led_q    <= img_q[2][`ESC_LED_LSB +: 2];
            pause_q  <= img_q[4][`ESC_CTL1_PAUSE];
            bkp_q    <= img_q[4][`ESC_CTL1_BKP];
            macfc_q  <= img_q[4][`ESC_CTL1_MACFC];
            storm_q  <= img_q[4][`ESC_CTL1_STORM];
            bpt_q    <= img_q[5][`ESC_CTL2_BPT_LSB +: 2];
            keep_q   <= img_q[6][`ESC_CTL3_KEEP];
            aging_q  <= img_q[6][`ESC_CTL3_AGING];
            idle64_q <= img_q[6][`ESC_CTL3_IDLE64];
            capbo_q  <= img_q[6][`ESC_CTL3_CAPBO];
        end else if (sw_wr) begin
            case (reg_addr)
                `ESC_OFS_LED: begin
                    led_q <= reg_wdata[`ESC_LED_LSB +: 2];
                end
                `ESC_OFS_CTL1: begin
                    pause_q <= reg_wdata[`ESC_CTL1_PAUSE];
                    bkp_q   <= reg_wdata[`ESC_CTL1_BKP];
                    macfc_q <= reg_wdata[`ESC_CTL1_MACFC];
                    storm_q <= reg_wdata[`ESC_CTL1_STORM];
                end
                `ESC_OFS_CTL2: begin
                    bpt_q <= reg_wdata[`ESC_CTL2_BPT_LSB +: 2];
                end
                `ESC_OFS_CTL3: begin
                    keep_q   <= reg_wdata[`ESC_CTL3_KEEP];
                    aging_q  <= reg_wdata[`ESC_CTL3_AGING];
                    idle64_q <= reg_wdata[`ESC_CTL3_IDLE64];
                    capbo_q  <= reg_wdata[`ESC_CTL3_CAPBO];
                end
                default: begin
                    led_q <= led_q;
                end
            endcase
        end
    end

    // Read mux mirrors the live fields in their image layout.
    always_comb begin
        rdata_d = 8'h00;
        case (reg_addr)
            `ESC_OFS_SIG0:   rdata_d = img_q[0];
            `ESC_OFS_SIG1:   rdata_d = img_q[1];
            `ESC_OFS_LED:    rdata_d = {6'h00, led_q};
            `ESC_OFS_CTL1:   rdata_d = {pause_q, 2'h0, bkp_q, macfc_q, storm_q, 2'h0}
                                       | {5'h00, `ESC_CTL1_RSVD};
            `ESC_OFS_CTL2:   rdata_d = {3'h0, bpt_q, 3'h0};
            `ESC_OFS_CTL3:   rdata_d = {keep_q, 2'h0, aging_q, 1'h0, idle64_q, capbo_q, 1'h0};
            `ESC_OFS_STATUS: rdata_d = {6'h00, sigok_q, ready_q};
            default:         rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign reg_rdata                 = rdata_q;
    assign led_mode                  = led_q;
    assign pause_enable              = pause_q;
    assign backpressure_enable       = bkp_q;
    assign mac_flow_enable           = macfc_q;
    assign bcast_storm_drop_enable   = storm_q;
    assign backpressure_type         = bpt_q;
    assign keep_after_max_collisions = keep_q;
    assign aging_enable              = aging_q;
    assign carrier_idle_64           = idle64_q;
    assign capped_backoff            = capbo_q;
    assign cfg_ready                 = ready_q;
    assign sig_valid                 = sigok_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_loads(logic [7:0] b, int pos, logic q);
        apply_ok |=> (q == $past(b[pos]));
    endproperty

    a_sig_gates_load: assert property (
        (st_q == esc_pkg::ESC_ST_APPLY) && !apply_ok |=> $stable(led_q) && $stable(pause_q)
        && $stable(bpt_q) && $stable(keep_q) && !sigok_q)
        else $error("Settings changed without a valid signature.");
    a_sig_flag_match: assert property (
        (st_q == esc_pkg::ESC_ST_APPLY) |=> (sigok_q == $past(apply_ok)) && ready_q)
        else $error("Signature flag does not follow the comparison.");
    a_led_loaded: assert property (
        apply_ok |=> (led_q == $past(img_q[2][1:0])))
        else $error("LED mode not loaded from byte two.");
    a_pause_loaded: assert property (p_loads(img_q[4], 7, pause_q))
        else $error("Pause enable not loaded.");
    a_bkp_loaded: assert property (p_loads(img_q[4], 4, bkp_q))
        else $error("Backpressure enable not loaded.");
    a_macfc_loaded: assert property (p_loads(img_q[4], 3, macfc_q))
        else $error("MAC port flow control not loaded.");
    a_storm_loaded: assert property (p_loads(img_q[4], 2, storm_q))
        else $error("Storm drop enable not loaded.");
    a_bptype_loaded: assert property (
        apply_ok |=> (bpt_q == $past(img_q[5][4:3])))
        else $error("Backpressure type not loaded.");
    a_keep_loaded: assert property (p_loads(img_q[6], 7, keep_q))
        else $error("Collision keep bit not loaded.");
    a_aging_loaded: assert property (p_loads(img_q[6], 4, aging_q))
        else $error("Aging enable not loaded.");
    a_idle_loaded: assert property (p_loads(img_q[6], 2, idle64_q))
        else $error("Carrier idle check not loaded.");
    a_capbo_loaded: assert property (p_loads(img_q[6], 1, capbo_q))
        else $error("Backoff cap not loaded.");
    a_ctl1_mirror: assert property (
        reg_rd && (reg_addr == `ESC_OFS_CTL1)
        |=> (reg_rdata == $past({pause_q, 2'h0, bkp_q, macfc_q, storm_q, 2'h1})))
        else $error("Control byte one read does not mirror the fields.");

    c_valid_load: cover property (apply_ok ##1 cfg_ready);
    c_no_sig: cover property ((st_q == esc_pkg::ESC_ST_APPLY) && !apply_ok);
    c_sw_write: cover property (sw_wr && (reg_addr == `ESC_OFS_CTL3));

endmodule : esc_loader

// file: esc_params.svh
// Purpose: Offsets, field positions, reset values and counts of the switch configuration loader.
// Assumes: Byte-wide configuration image read from a serial EEPROM after reset.
// Notes: Definitions only.
`ifndef ESC_PARAMS_SVH
`define ESC_PARAMS_SVH

`define ESC_OFS_SIG0      8'h00
`define ESC_OFS_SIG1      8'h01
`define ESC_OFS_LED       8'h02
`define ESC_OFS_SPARE     8'h03
`define ESC_OFS_CTL1      8'h04
`define ESC_OFS_CTL2      8'h05
`define ESC_OFS_CTL3      8'h06
`define ESC_OFS_STATUS    8'h10

`define ESC_IMG_LAST      3'h6
`define ESC_SIG_BYTE0     8'h55
`define ESC_SIG_BYTE1     8'haa

`define ESC_LED_LSB       0
`define ESC_CTL1_PAUSE    7
`define ESC_CTL1_BKP      4
`define ESC_CTL1_MACFC    3
`define ESC_CTL1_STORM    2
`define ESC_CTL2_BPT_LSB  3
`define ESC_CTL3_KEEP     7
`define ESC_CTL3_AGING    4
`define ESC_CTL3_IDLE64   2
`define ESC_CTL3_CAPBO    1

`define ESC_RST_LED       2'h3
`define ESC_RST_PAUSE     1'h1
`define ESC_RST_BKP       1'h1
`define ESC_RST_MACFC     1'h1
`define ESC_RST_STORM     1'h0
`define ESC_RST_BPT       2'h0
`define ESC_RST_KEEP      1'h1
`define ESC_RST_AGING     1'h1
`define ESC_RST_IDLE64    1'h1
`define ESC_RST_CAPBO     1'h1
`define ESC_CTL1_RSVD     3'h1

`define ESC_ROM_WAIT      8'hff

`endif

// file: esc_pkg.sv
// Purpose: Types of the switch configuration loader.
// Assumes: Used by name, never imported.
// Notes: State codes are one-hot.
package esc_pkg;

    typedef enum logic [3:0] {
        ESC_ST_STRAP = 4'h1,
        ESC_ST_FETCH = 4'h2,
        ESC_ST_APPLY = 4'h4,
        ESC_ST_RUN   = 4'h8
    } esc_load_state_t;

    typedef enum logic [3:0] {
        ESC_RD_IDLE = 4'h1,
        ESC_RD_ASK  = 4'h2,
        ESC_RD_WAIT = 4'h4,
        ESC_RD_DONE = 4'h8
    } esc_read_state_t;

endpackage : esc_pkg

// file: esc_rom_if.sv
// Purpose: Carries image bytes from the EEPROM reader to the loader.
// Assumes: One clock domain.
// Notes: Byte strobe and done are one-cycle pulses.
`timescale 1ns/10ps
interface esc_rom_if;
    logic       start;
    logic       byte_valid;
    logic [2:0] byte_idx;
    logic [7:0] byte_data;
    logic       done;
    logic       timed_out;

    modport loader (output start, input byte_valid, byte_idx, byte_data, done, timed_out);
    modport reader (input start, output byte_valid, byte_idx, byte_data, done, timed_out);
endinterface : esc_rom_if

// file: esc_rom_reader.sv
// Purpose: Reads image bytes zero to six from the EEPROM byte port in order.
// Assumes: The EEPROM answers each request with one rom_valid pulse.
// Notes: A request left unanswered too long ends the read as timed out.
`timescale 1ns/10ps
`include "esc_params.svh"
module esc_rom_reader (
    input  wire logic sys_clk,
    input  wire logic rst,
    esc_rom_if.reader rd,
    output logic       rom_req,
    output logic [7:0] rom_addr,
    input  wire logic [7:0] rom_data,
    input  wire logic       rom_valid
);
    esc_pkg::esc_read_state_t st_q;
    logic [2:0] idx_q;
    logic [7:0] wait_q;
    logic       req_q;
    logic [7:0] addr_q;
    logic       bvalid_q;
    logic [7:0] bdata_q;
    logic [2:0] bidx_q;
    logic       done_q;
    logic       tout_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_q     <= esc_pkg::ESC_RD_IDLE;
            idx_q    <= 3'h0;
            wait_q   <= 8'h00;
            req_q    <= 1'b0;
            addr_q   <= 8'h00;
            bvalid_q <= 1'b0;
            bdata_q  <= 8'h00;
            bidx_q   <= 3'h0;
            done_q   <= 1'b0;
            tout_q   <= 1'b0;
        end else begin
            req_q    <= 1'b0;
            bvalid_q <= 1'b0;
            done_q   <= 1'b0;
            case (st_q)
                esc_pkg::ESC_RD_IDLE: begin
                    if (rd.start) begin
                        idx_q  <= 3'h0;
                        tout_q <= 1'b0;
                        st_q   <= esc_pkg::ESC_RD_ASK;
                    end
                end
                esc_pkg::ESC_RD_ASK: begin
                    req_q  <= 1'b1;
                    addr_q <= {5'h00, idx_q};
                    wait_q <= 8'h00;
                    st_q   <= esc_pkg::ESC_RD_WAIT;
                end
                esc_pkg::ESC_RD_WAIT: begin
                    if (rom_valid) begin
                        bvalid_q <= 1'b1;
                        bdata_q  <= rom_data;
                        bidx_q   <= idx_q;
                        if (idx_q == `ESC_IMG_LAST) begin
                            st_q <= esc_pkg::ESC_RD_DONE;
                        end else begin
                            idx_q <= idx_q + 3'h1;
                            st_q  <= esc_pkg::ESC_RD_ASK;
                        end
                    end else if (wait_q == `ESC_ROM_WAIT) begin
                        tout_q <= 1'b1;
                        st_q   <= esc_pkg::ESC_RD_DONE;
                    end else begin
                        wait_q <= wait_q + 8'h01;
                    end
                end
                esc_pkg::ESC_RD_DONE: begin
                    done_q <= 1'b1;
                    st_q   <= esc_pkg::ESC_RD_IDLE;
                end
                default: begin
                    st_q <= esc_pkg::ESC_RD_IDLE;
                end
            endcase
        end
    end

    assign rom_req       = req_q;
    assign rom_addr      = addr_q;
    assign rd.byte_valid = bvalid_q;
    assign rd.byte_idx   = bidx_q;
    assign rd.byte_data  = bdata_q;
    assign rd.done       = done_q;
    assign rd.timed_out  = tout_q;

    a_req_one_cycle: assert property (@(posedge sys_clk) disable iff (rst)
        rom_req |=> !rom_req)
        else $error("EEPROM request held longer than one cycle.");
    a_wait_bounded: assert property (@(posedge sys_clk) disable iff (rst)
        rom_req |-> ##[1:257] (bvalid_q || tout_q))
        else $error("EEPROM request neither answered nor timed out.");
    c_timeout_seen: cover property (@(posedge sys_clk) disable iff (rst) done_q && tout_q);

endmodule : esc_rom_reader

// file: esc_eeprom_model.sv
// Purpose: Behavioural serial configuration EEPROM that answers byte requests of the loader.
// Assumes: One request outstanding at a time; latency counted from the request cycle.
// Notes: A latency of zero never answers; the data lines churn whenever no byte is presented.
`timescale 1ns/10ps
module esc_eeprom_model (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [55:0] img,
    input  wire logic [9:0]  lat,
    input  wire logic        rom_req,
    input  wire logic [7:0]  rom_addr,
    output logic [7:0]       rom_data,
    output logic             rom_valid
);
    int         cnt;
    logic [2:0] idx;

    initial begin
        cnt       = 0;
        idx       = 3'h0;
        rom_data  = 8'h00;
        rom_valid = 1'b0;
    end

    // The image keeps the signature in its bytes zero and one.
    always @(posedge sys_clk) begin
        if (rst) begin
            cnt = 0;
        end else if (rom_req) begin
            cnt = lat;
            idx = rom_addr[2:0];
        end
        if (cnt == 1) begin
            rom_valid <= 1'b1;
            rom_data  <= img[idx*8 +: 8];
        end else begin
            rom_valid <= 1'b0;
            rom_data  <= ~rom_data;
        end
        if (cnt != 0) begin
            cnt = cnt - 1;
        end
    end
endmodule : esc_eeprom_model

// file: tb_eeprom_switch_config.sv
// Purpose: Self-checking bench of the switch configuration loader.
// Assumes: Register reads answer in the next cycle; the EEPROM model answers after lat cycles.
// Notes: Expected read data are queued by the driver and compared by a separate monitor.
`timescale 1ns/10ps
module tb_eeprom_switch_config;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic [6:0]  strap = 7'h00;
    logic        rom_req;
    logic [7:0]  rom_addr;
    logic [7:0]  rom_data;
    logic        rom_valid;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_rdata;
    logic [1:0]  led_mode;
    logic [1:0]  backpressure_type;
    logic        pause_enable, backpressure_enable, mac_flow_enable, bcast_storm_drop_enable;
    logic        keep_after_max_collisions, aging_enable, carrier_idle_64, capped_backoff;
    logic        cfg_ready, sig_valid, rd_q = 1'b0;
    logic [55:0] img = 56'h0;
    logic [9:0]  lat = 10'h1;
    logic [15:0] seed = 16'h2f24;
    logic [7:0]  exp_q[$];
    int          n_mismatch = 0;
    int          n_tests = 0;

    always #20 sys_clk = ~sys_clk;

    esc_loader i_dut (.sys_clk(sys_clk), .rst(rst), .strap_led_mode(strap[6:5]),
        .strap_pause_enable(strap[4]), .strap_backpressure_enable(strap[3]),
        .strap_mac_flow_enable(strap[2]), .strap_bcast_storm_drop_enable(strap[1]),
        .strap_aging_enable(strap[0]), .rom_req(rom_req), .rom_addr(rom_addr),
        .rom_data(rom_data), .rom_valid(rom_valid), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .led_mode(led_mode), .pause_enable(pause_enable),
        .backpressure_enable(backpressure_enable), .mac_flow_enable(mac_flow_enable),
        .bcast_storm_drop_enable(bcast_storm_drop_enable),
        .backpressure_type(backpressure_type),
        .keep_after_max_collisions(keep_after_max_collisions), .aging_enable(aging_enable),
        .carrier_idle_64(carrier_idle_64), .capped_backoff(capped_backoff),
        .cfg_ready(cfg_ready), .sig_valid(sig_valid));

    esc_eeprom_model i_rom (.sys_clk(sys_clk), .rst(rst), .img(img), .lat(lat),
        .rom_req(rom_req), .rom_addr(rom_addr), .rom_data(rom_data), .rom_valid(rom_valid));

    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr_next

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic end_sim;
        $display("mismatches=%0d comparisons=%0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        exp_q.push_back(e);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
    endtask : rd

    // Read data stand only in the cycle after the strobe; compare them there.
    always @(posedge sys_clk) begin
        if (rd_q) begin
            if (exp_q.size() == 0) begin
                chk(16'hdead, 16'h0000);
            end else begin
                chk({8'h00, reg_rdata}, {8'h00, exp_q.pop_front()});
            end
        end
        rd_q <= reg_rd;
    end

    task automatic run_pass(input logic [7:0] b1, input logic [9:0] l, input logic [1:0] bc);
        logic [7:0] b[7];
        logic       ok;
        logic [1:0] e_led, e_bpt;
        logic       e_p, e_b, e_m, e_s, e_k, e_a, e_i, e_c;
        int         n;
        for (n = 2; n < 7; n++) begin
            seed = lfsr_next(seed);
            b[n] = seed[7:0];
        end
        seed = lfsr_next(seed);
        b[0] = 8'h55;
        b[1] = b1;
        b[5] = (b[5] & 8'he7) | {3'h0, bc, 3'h0};
        ok   = (b1 == 8'haa) && (l != 10'h0) && (l < 10'h100);
        rst   <= 1'b1;
        strap <= seed[6:0];
        img   <= {b[6], b[5], b[4], b[3], b[2], b[1], b[0]};
        lat   <= l;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        wr(8'h02, 8'h00);
        for (n = 0; n < 3000 && cfg_ready !== 1'b1; n++) begin
            @(posedge sys_clk);
        end
        #1;
        e_led = ok ? b[2][1:0] : strap[6:5];
        e_p   = ok ? b[4][7] : strap[4];
        e_b   = ok ? b[4][4] : strap[3];
        e_m   = ok ? b[4][3] : strap[2];
        e_s   = ok ? b[4][2] : strap[1];
        e_bpt = ok ? b[5][4:3] : 2'h0;
        e_k   = ok ? b[6][7] : 1'b1;
        e_a   = ok ? b[6][4] : strap[0];
        e_i   = ok ? b[6][2] : 1'b1;
        e_c   = ok ? b[6][1] : 1'b1;
        chk({2'h0, led_mode, pause_enable, backpressure_enable, mac_flow_enable,
             bcast_storm_drop_enable, backpressure_type, keep_after_max_collisions,
             aging_enable, carrier_idle_64, capped_backoff, cfg_ready, sig_valid},
            {2'h0, e_led, e_p, e_b, e_m, e_s, e_bpt, e_k, e_a, e_i, e_c, 1'b1, ok});
        rd(8'h02, {6'h00, e_led});
        rd(8'h04, {e_p, 2'h0, e_b, e_m, e_s, 2'h1});
        rd(8'h05, {3'h0, e_bpt, 3'h0});
        rd(8'h06, {e_k, 2'h0, e_a, 1'b0, e_i, e_c, 1'b0});
        rd(8'h10, {6'h00, ok, 1'b1});
        rd(8'h03, 8'h00);
    endtask : run_pass

    initial begin
        #(40 * 60000);
        n_mismatch++;
        end_sim();
    end

    initial begin
        run_pass(8'haa, 10'h001, 2'h0);
        wr(8'h01, 8'h3c);
        rd(8'h01, 8'h3c);
        rd(8'h00, 8'h55);
        wr(8'h04, 8'h00);
        rd(8'h04, 8'h01);
        wr(8'h05, 8'h10);
        wr(8'h06, 8'hff);
        rd(8'h06, 8'h96);
        wr(8'h03, 8'hff);
        rd(8'h03, 8'h00);
        rd(8'h7f, 8'h00);
        wr(8'h02, 8'hfe);
        rd(8'h05, 8'h10);
        #1;
        chk({led_mode, backpressure_type, pause_enable, sig_valid}, {2'h2, 2'h2, 1'b0, 1'b1});
        run_pass(8'haa, 10'h005, 2'h1);
        run_pass(8'haa, 10'h0ff, 2'h1);
        run_pass(8'haa, 10'h100, 2'h2);
        run_pass(8'hab, 10'h003, 2'h1);
        run_pass(8'haa, 10'h000, 2'h2);
        repeat (4) @(posedge sys_clk);
        chk(16'(exp_q.size()), 16'h0000);
        end_sim();
    end
endmodule : tb_eeprom_switch_config
